// >>> hw/window_watchdog_pkg.sv
// Constants, field layouts and types shared by the window watchdog
package window_watchdog_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL    = 8'h00;
  localparam logic [7:0] OFS_CONFIG     = 8'h04;
  localparam logic [7:0] OFS_STATUS     = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         CTRL_EN_BIT    = 7;
  localparam int         CNT_TOP_BIT    = 6;
  localparam int         CNT_MSB        = 6;
  localparam int         CFG_WIN_MSB    = 6;
  localparam int         CFG_DIV_LSB    = 7;
  localparam int         CFG_DIV_MSB    = 8;
  localparam int         CFG_IEN_BIT    = 9;
  localparam int         STS_FLAG_BIT   = 0;
  localparam logic [6:0] CNT_RESET      = 7'h7F;
  localparam logic [6:0] WIN_RESET      = 7'h7F;
  localparam logic [1:0] DIV_RESET      = 2'h0;
  localparam logic [6:0] WARN_VALUE     = 7'h40;
  localparam logic [6:0] WARN_NEXT      = 7'h41;
  localparam int         IRQ_WIDTH      = 2;
  localparam int         IRQ_WARN_BIT   = 0;
  localparam int         IRQ_TRIP_BIT   = 1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         BASE_DIVIDE    = 4096;
  localparam int         DIV_WIDTH      = 16;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_type;

  typedef struct packed {
    logic       irq_enable;
    logic [1:0] divide;
    logic [6:0] window;
  } cfg_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_TRIP = 3'b100
  } wd_state_type;

endpackage

// >>> hw/tick_divider.sv
// Prescaler that turns the bus clock into downcounter step pulses
`timescale 1ns/1ps
module tick_divider #(
  parameter int BASE_DIVIDE = window_watchdog_pkg::BASE_DIVIDE
) (
  input  wire logic       clk_sys_in,
  input  wire logic       nrst_in,
  input  wire logic       run_in,
  input  wire logic       hold_in,
  input  wire logic [1:0] sel_in,
  output logic            tick_out
);

  localparam int W = window_watchdog_pkg::DIV_WIDTH;
  localparam logic [W-1:0] BASE_W = W'(BASE_DIVIDE);
  localparam logic [W-1:0] ONE_W  = W'(1);

  logic [W-1:0] count;
  logic [W-1:0] limit;

  assign limit    = (BASE_W << sel_in) - ONE_W;
  // Compare with >= so a smaller divide picked mid-count cannot stall
  assign tick_out = run_in & ~hold_in & (count >= limit);

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count <= '0;
    end else if (!run_in) begin
      count <= '0;
    end else if (tick_out) begin
      count <= '0;
    end else if (!hold_in) begin
      count <= count + ONE_W;
    end
  end

endmodule

// >>> hw/window_watchdog.sv
// Window watchdog: register port, downcounter, window checks, interrupt
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
// How it works
// - Enabled counter stepping from 0x40 to 0x3F requests a system reset.
// - Enabled reload while counter exceeds window value requests reset.
// - Counter steps every 4096 times 2^select bus clocks.
// - Reaching 0x40 sets the warning flag and, if enabled, interrupts.
// - Enabling with written counter bit 6 zero resets at once.
// - Enable bit at control bit 7 is set by one, cleared by reset.
// - Debug halt with freeze selected stops the counter.
// - Control 0x00, configuration 0x04, status 0x08; no byte access.
// - Counter is control bits 6 to 0, read/write, resets to 0x7F.
// - Window value sits in configuration bits 6 to 0, resets to 0x7F.
// - Configuration bit 9 enables the warning interrupt, bits 8 to 7 select divide.
// - Status bit 0 is the warning flag, cleared by writing zero.
module window_watchdog #(
  parameter int BASE_DIVIDE = window_watchdog_pkg::BASE_DIVIDE
) (
  input  wire logic                             clk_sys_in,
  input  wire logic                             nrst_in,
  input  wire window_watchdog_pkg::bus_req_type bus_req_in,
  output logic [31:0]                           bus_rdata_out,
  input  wire logic                             core_halted_in,
  input  wire logic                             debug_halt_freeze_in,
  output logic                                  irq_out,
  output logic                                  reset_request_out
);

  localparam int IW = window_watchdog_pkg::IRQ_WIDTH;

  window_watchdog_pkg::wd_state_type state;
  window_watchdog_pkg::wd_state_type next_state;
  window_watchdog_pkg::cfg_type      cfg;

  logic [6:0]    counter;
  logic          reload_warning_flag;
  logic [IW-1:0] irq_status;
  logic [IW-1:0] irq_enable;
  logic [31:0]   next_rdata;
  logic [31:0]   wdata;
  logic          wr_ctrl;
  logic          wr_cfg;
  logic          wr_sts;
  logic          wr_iclr;
  logic          wr_ien;
  logic          enabled;
  logic          freeze;
  logic          tick;
  logic          step;
  logic          underflow;
  logic          window_bad;
  logic          enable_bad;
  logic          warn_hit;
  logic          trip_event;
  logic [IW-1:0] irq_set;

  assign wdata = bus_req_in.wdata;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  // Port carries no byte lanes, so every write is taken as a full word
  always_comb begin
    wr_ctrl = 1'b0;
    wr_cfg  = 1'b0;
    wr_sts  = 1'b0;
    wr_iclr = 1'b0;
    wr_ien  = 1'b0;
    if (bus_req_in.wr) begin
      if (bus_req_in.addr == window_watchdog_pkg::OFS_CONTROL) begin
        wr_ctrl = 1'b1;
      end else if (bus_req_in.addr == window_watchdog_pkg::OFS_CONFIG) begin
        wr_cfg = 1'b1;
      end else if (bus_req_in.addr == window_watchdog_pkg::OFS_STATUS) begin
        wr_sts = 1'b1;
      end else if (bus_req_in.addr ==
                   window_watchdog_pkg::OFS_IRQ_CLEAR) begin
        wr_iclr = 1'b1;
      end else if (bus_req_in.addr ==
                   window_watchdog_pkg::OFS_IRQ_ENABLE) begin
        wr_ien = 1'b1;
      end
    end
  end

  always_comb begin
    next_rdata = '0;
    if (bus_req_in.rd) begin
      if (bus_req_in.addr == window_watchdog_pkg::OFS_CONTROL) begin
        next_rdata[window_watchdog_pkg::CTRL_EN_BIT] = enabled;
        next_rdata[window_watchdog_pkg::CNT_MSB:0]   = counter;
      end else if (bus_req_in.addr == window_watchdog_pkg::OFS_CONFIG) begin
        next_rdata[window_watchdog_pkg::CFG_IEN_BIT:0] = cfg;
      end else if (bus_req_in.addr == window_watchdog_pkg::OFS_STATUS) begin
        next_rdata[window_watchdog_pkg::STS_FLAG_BIT] = reload_warning_flag;
      end else if (bus_req_in.addr ==
                   window_watchdog_pkg::OFS_IRQ_STATUS) begin
        next_rdata[IW-1:0] = irq_status;
      end else if (bus_req_in.addr ==
                   window_watchdog_pkg::OFS_IRQ_ENABLE) begin
        next_rdata[IW-1:0] = irq_enable;
      end
    end
  end

  // Read data stand for one cycle only, zero otherwise
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bus_rdata_out <= '0;
    end else begin
      bus_rdata_out <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg.irq_enable <= 1'b0;
      cfg.divide     <= window_watchdog_pkg::DIV_RESET;
      cfg.window     <= window_watchdog_pkg::WIN_RESET;
    end else if (wr_cfg) begin
      cfg.irq_enable <= wdata[window_watchdog_pkg::CFG_IEN_BIT];
      cfg.divide     <= wdata[window_watchdog_pkg::CFG_DIV_MSB:
                              window_watchdog_pkg::CFG_DIV_LSB];
      cfg.window     <= wdata[window_watchdog_pkg::CFG_WIN_MSB:0];
    end
  end

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  assign enabled = (state != window_watchdog_pkg::ST_IDLE);
  assign freeze  = core_halted_in & debug_halt_freeze_in;

  tick_divider #(
    .BASE_DIVIDE (BASE_DIVIDE)
  ) u_divider (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .run_in     (enabled),
    .hold_in    (freeze),
    .sel_in     (cfg.divide),
    .tick_out   (tick)
  );

  // ----------------------------------------------------------------
  // Downcounter and reset conditions
  // ----------------------------------------------------------------
  // A counter write in the same cycle as a step wins over the step
  assign step       = enabled & tick & ~wr_ctrl;
  assign underflow  = step &
                      (counter == window_watchdog_pkg::WARN_VALUE);
  assign warn_hit   = step &
                      (counter == window_watchdog_pkg::WARN_NEXT);
  assign window_bad = enabled & wr_ctrl & (counter > cfg.window);
  // Loading below 0x40 while on, or switching on there, trips at once
  assign enable_bad = wr_ctrl & ~wdata[window_watchdog_pkg::CNT_TOP_BIT] &
                      (wdata[window_watchdog_pkg::CTRL_EN_BIT] |
                       enabled);

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      counter <= window_watchdog_pkg::CNT_RESET;
    end else if (wr_ctrl) begin
      counter <= wdata[window_watchdog_pkg::CNT_MSB:0];
    end else if (step) begin
      counter <= counter - 7'h01;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      window_watchdog_pkg::ST_IDLE: begin
        if (wr_ctrl && wdata[window_watchdog_pkg::CTRL_EN_BIT]) begin
          if (enable_bad) begin
            next_state = window_watchdog_pkg::ST_TRIP;
          end else begin
            next_state = window_watchdog_pkg::ST_RUN;
          end
        end
      end
      window_watchdog_pkg::ST_RUN: begin
        if (underflow || window_bad || enable_bad) begin
          next_state = window_watchdog_pkg::ST_TRIP;
        end
      end
      window_watchdog_pkg::ST_TRIP: begin
        next_state = window_watchdog_pkg::ST_TRIP;
      end
      default: begin
        next_state = window_watchdog_pkg::ST_IDLE;
      end
    endcase
  end

  // Enable never falls back to idle: only the reset input clears it
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= window_watchdog_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Held until the system reset arrives
  assign reset_request_out = (state == window_watchdog_pkg::ST_TRIP);
  assign trip_event = (next_state == window_watchdog_pkg::ST_TRIP) &&
                      (state != window_watchdog_pkg::ST_TRIP);

  // ----------------------------------------------------------------
  // Warning flag and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reload_warning_flag <= 1'b0;
    end else if (warn_hit) begin
      reload_warning_flag <= 1'b1;
    end else if (wr_sts && !wdata[window_watchdog_pkg::STS_FLAG_BIT]) begin
      reload_warning_flag <= 1'b0;
    end
  end

  always_comb begin
    irq_set = '0;
    irq_set[window_watchdog_pkg::IRQ_WARN_BIT] = warn_hit & cfg.irq_enable;
    irq_set[window_watchdog_pkg::IRQ_TRIP_BIT] = trip_event;
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_status <= '0;
    end else if (wr_iclr) begin
      irq_status <= (irq_status & ~wdata[IW-1:0]) | irq_set;
    end else begin
      irq_status <= irq_status | irq_set;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_enable <= '0;
    end else if (wr_ien) begin
      irq_enable <= wdata[IW-1:0];
    end
  end

  assign irq_out = |(irq_status & irq_enable);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  localparam int W = window_watchdog_pkg::DIV_WIDTH;

  logic [W-1:0] gap;
  logic         gap_ok;
  logic [W-1:0] gap_limit;

  assign gap_limit = (W'(BASE_DIVIDE) << cfg.divide) - W'(1);

  // Active cycles since the last step, valid once one step was seen
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gap    <= '0;
      gap_ok <= 1'b0;
    end else if (!enabled || wr_cfg) begin
      gap    <= '0;
      gap_ok <= 1'b0;
    end else if (tick) begin
      gap    <= '0;
      gap_ok <= 1'b1;
    end else if (!freeze) begin
      gap    <= gap + W'(1);
    end
  end

  a_step_period:
    assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (tick && gap_ok) |-> (gap == gap_limit))
    else $error("step period differs from prescale setting");

  a_underflow_trip:
    assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (state == window_watchdog_pkg::ST_RUN && tick && !wr_ctrl &&
       counter == 7'h40) |=> reset_request_out)
    else $error("no reset request after 0x40 to 0x3F");

  a_window_reload:
    assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (enabled && wr_ctrl && counter > cfg.window) |=> reset_request_out)
    else $error("reload above window did not trip");

  a_enable_low_count:
    assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (wr_ctrl && wdata[7] && !wdata[6]) |=> reset_request_out)
    else $error("enable with counter bit 6 clear did not trip");

  a_enable_sticky:
    assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      enabled |=> enabled [*3])
    else $error("enable bit cleared without reset");

  a_freeze_holds:
    assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (core_halted_in && debug_halt_freeze_in && !wr_ctrl)
        |=> (counter == $past(counter)))
    else $error("counter moved while frozen for debug");

  a_load_value:
    assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      wr_ctrl |=> (counter == $past(wdata[6:0])))
    else $error("counter write not loaded");

  a_warn_flag:
    assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (enabled && tick && !wr_ctrl && counter == 7'h41)
        |=> (reload_warning_flag && counter == 7'h40))
    else $error("warning flag not set on reaching 0x40");

  a_warn_irq:
    assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (enabled && tick && !wr_ctrl && counter == 7'h41 &&
       cfg.irq_enable && irq_enable[0] && !wr_ien) |=> irq_out)
    else $error("warning interrupt not raised");

  a_flag_set_wins:
    assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (warn_hit && wr_sts && !wdata[0]) |=> reload_warning_flag)
    else $error("warning flag lost to a clear");

  a_quiet_disabled:
    assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (!enabled) |-> !reset_request_out)
    else $error("reset request while disabled");

  a_reset_values:
    assert property (@(posedge clk_sys_in)
      $rose(nrst_in) |-> (counter == 7'h7F && cfg.window == 7'h7F &&
                          !reload_warning_flag))
    else $error("wrong values after reset");

endmodule

// >>> sim/tb_window_watchdog.sv
// Self-checking bench for the window watchdog over its register port
`timescale 1ns/1ps
module tb_window_watchdog;
  // ----------------------------------------------------------------
  // Clock, reset and design hookup
  // ----------------------------------------------------------------
  // Short prescale base keeps every divide select well inside the run
  localparam int         DIVB  = 4;
  localparam int         LIMIT = 20000;
  localparam logic [7:0] A_CTL = window_watchdog_pkg::OFS_CONTROL;
  localparam logic [7:0] A_CFG = window_watchdog_pkg::OFS_CONFIG;
  localparam logic [7:0] A_STS = window_watchdog_pkg::OFS_STATUS;
  localparam logic [7:0] A_IST = window_watchdog_pkg::OFS_IRQ_STATUS;
  localparam logic [7:0] A_ICL = window_watchdog_pkg::OFS_IRQ_CLEAR;
  localparam logic [7:0] A_IEN = window_watchdog_pkg::OFS_IRQ_ENABLE;

  logic                             clk_sys_in = 1'b0;
  logic                             nrst_in    = 1'b0;
  window_watchdog_pkg::bus_req_type bus_req    = '0;
  logic [31:0]                      bus_rdata;
  logic                             core_halted = 1'b0;
  logic                             freeze      = 1'b0;
  logic                             irq;
  logic                             rst_req;
  int                               cyc = 0;
  int                               err_count = 0;
  int                               n_tests = 0;
  logic [31:0]                      v;
  logic [31:0]                      v1;
  int                               t0;
  int                               p;
  int                               el;

  always #10 clk_sys_in = ~clk_sys_in;

  window_watchdog #(.BASE_DIVIDE(DIVB)) window_watchdog_inst (
    .clk_sys_in           (clk_sys_in),
    .nrst_in              (nrst_in),
    .bus_req_in           (bus_req),
    .bus_rdata_out        (bus_rdata),
    .core_halted_in       (core_halted),
    .debug_halt_freeze_in (freeze),
    .irq_out              (irq),
    .reset_request_out    (rst_req)
  );

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc >= LIMIT) begin
      err_count++;
      close_out();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Strobes rise after one edge and drop after the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge clk_sys_in);
    bus_req.wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge clk_sys_in);
    bus_req.rd   <= 1'b0;
    #1 d = bus_rdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                       input string name);
    logic [31:0] d;
    rd(a, d);
    chk(name, exp, d);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  // Driven just after a rising edge so release never races the flops
  task automatic do_reset();
    @(posedge clk_sys_in);
    nrst_in <= 1'b0;
    repeat (5) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    chk("rst_req", 0, rst_req);
    rdchk(A_CTL, 32'h7F, "ctrl_reset");
    settle(1);
    chk("rdata_idle", 0, bus_rdata);
    rdchk(A_CFG, 32'h7F, "cfg_reset");
    rdchk(A_STS, 32'h0, "sts_reset");
    rdchk(A_IST, 32'h0, "ist_reset");
    rdchk(A_IEN, 32'h0, "ien_reset");
    wr(8'h20, 32'hFFFF_FFFF);
    rdchk(8'h20, 32'h0, "unmapped");
    rdchk(A_CTL, 32'h7F, "ctrl_after_unmapped");
    // Disabled: no trip whatever is written, counter does not step
    wr(A_CFG, 32'h41);
    wr(A_CTL, 32'h7F);
    wr(A_CTL, 32'h3F);
    wr(A_CTL, 32'h00);
    settle(200);
    chk("rst_disabled", 0, rst_req);
    rdchk(A_CTL, 32'h00, "ctrl_disabled_hold");
    // Step period for each divide select
    for (int s = 0; s < 4; s++) begin
      do_reset();
      wr(A_CFG, (32'(s) << 7) | 32'h7F);
      rdchk(A_CFG, (32'(s) << 7) | 32'h7F, "cfg_div");
      wr(A_CTL, 32'hFF);
      t0 = cyc;
      p = DIVB << s;
      while (cyc < t0 + 3 * p + p / 2 - 2) @(posedge clk_sys_in);
      rd(A_CTL, v);
      el = cyc - t0;
      chk("ctrl_step", 32'h80 | (32'h7F - 32'(el / p)), v);
    end
    // Debug freeze
    do_reset();
    wr(A_CTL, 32'hFF);
    @(posedge clk_sys_in);
    core_halted <= 1'b1;
    freeze      <= 1'b1;
    rd(A_CTL, v1);
    settle(60);
    rdchk(A_CTL, v1, "ctrl_frozen");
    @(posedge clk_sys_in);
    freeze <= 1'b0;
    settle(40);
    rd(A_CTL, v);
    chk("halt_only_steps", 1, 32'(v1 - v >= 8 && v1 - v <= 12));
    @(posedge clk_sys_in);
    core_halted <= 1'b0;
    // Early warning, interrupt and trip at 0x3F
    do_reset();
    wr(A_CFG, 32'h27F);
    wr(A_IEN, 32'h1);
    wr(A_CTL, 32'hC2);
    for (int i = 0; i < 40; i++) begin
      rd(A_STS, v);
      if (v[0] === 1'b1) break;
    end
    chk("warn_flag", 1, v);
    chk("irq_warn", 1, irq);
    chk("rst_at_40", 0, rst_req);
    for (int i = 0; i < 20 && rst_req !== 1'b1; i++) settle(1);
    chk("rst_at_3f", 1, rst_req);
    rdchk(A_IST, 32'h3, "ist_events");
    wr(A_IEN, 32'h0);
    settle(1);
    chk("irq_masked", 0, irq);
    wr(A_IEN, 32'h1);
    settle(1);
    chk("irq_unmasked", 1, irq);
    wr(A_ICL, 32'h1);
    settle(1);
    chk("irq_cleared", 0, irq);
    rdchk(A_IST, 32'h2, "ist_after_clear");
    wr(A_IEN, 32'h2);
    rdchk(A_IEN, 32'h2, "ien_readback");
    chk("irq_trip", 1, irq);
    wr(A_STS, 32'h1);
    rdchk(A_STS, 32'h1, "sts_write_one");
    wr(A_STS, 32'h0);
    rdchk(A_STS, 32'h0, "sts_write_zero");
    chk("rst_stands", 1, rst_req);
    // Clear meets the warning step, then the handler reloads on a step
    do_reset();
    wr(A_CFG, 32'h7F);
    wr(A_IEN, 32'h1);
    wr(A_CTL, 32'hC2);
    settle(6);
    wr(A_STS, 32'h0);
    rdchk(A_STS, 32'h1, "sts_set_wins");
    wr(A_CTL, 32'hFF);
    rdchk(A_IST, 32'h0, "ist_warn_gated");
    chk("irq_warn_gated", 0, irq);
    settle(20);
    chk("rst_handler_reload", 0, rst_req);
    // Reload inside the window, then outside it
    do_reset();
    wr(A_CFG, 32'h1FF);
    wr(A_CTL, 32'hFE);
    wr(A_CTL, 32'h70);
    rdchk(A_CTL, 32'hF0, "reload_keeps_enable");
    settle(3);
    chk("rst_legal_reload", 0, rst_req);
    wr(A_CFG, 32'h1D0);
    wr(A_CTL, 32'hF0);
    settle(2);
    chk("rst_early_reload", 1, rst_req);
    // Enabling with counter bit 6 clear
    do_reset();
    wr(A_CTL, 32'hBF);
    settle(2);
    chk("rst_enable_low", 1, rst_req);
    do_reset();
    settle(2);
    chk("rst_cleared", 0, rst_req);
    close_out();
  end
endmodule
